// File: core/adc_frame_params.svh
// Purpose: Constants for the serial frame and power-mode controller.
// Assumes: 10 MHz ref_clk; serial clock far slower than ref_clk.
// Notes:   Offsets are APB byte addresses; times in their own units.
`ifndef ADC_FRAME_PARAMS_SVH
`define ADC_FRAME_PARAMS_SVH

`define OFF_CTRL        8'h00
`define OFF_RANGE       8'h04
`define OFF_STATUS      8'h08
`define OFF_CONV        8'h0C

`define CTRL_RESET      12'h000
`define RANGE_RESET     6'h00
`define CONV_RESET      13'h0000

`define PM_HI_BIT       11
`define PM_LO_BIT       10
`define REF_BIT         1
`define CHAN_BIT        9
`define CODE_CTRL       3'h4
`define CODE_RANGE      3'h5

`define FRAME_BITS      16
`define TRACK_EDGE      14
`define CTRL_EDGE       15
`define RANGE_EDGE      11

`define CLK_PERIOD_NS   100
`define WAKE_SD_US      500
`define WAKE_SB_NS      750
`define WAKE_SD_CYC     ((`WAKE_SD_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_SB_CYC     ((`WAKE_SB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: core/adc_frame_pkg.sv
// Purpose: Types for the serial frame and power-mode controller.
// Assumes: Nothing beyond the constants header.
// Notes:   Power state codes are Gray coded in declaration order, not along the sleep and wake path.
`default_nettype none
package adc_frame_pkg;

  typedef enum logic [2:0] {
    PWR_ON      = 3'h0,
    PWR_STANDBY = 3'h1,
    PWR_AUTO_SD = 3'h3,
    PWR_FULL_SD = 3'h2,
    PWR_WAKE    = 3'h6
  } pwr_state_t;

endpackage : adc_frame_pkg
`default_nettype wire

// File: core/adc_frame_ctrl.sv
// Purpose: Serial frame engine, register decode and power modes.
// Assumes: Link pins are asynchronous and sampled by ref_clk.
// Notes:   APB registers mirror on-chip state and feed the result word.
`include "adc_frame_params.svh"
`default_nettype none

module adc_frame_ctrl
  import adc_frame_pkg::*;
#(
  parameter int WAKE_SD_CYCLES   = `WAKE_SD_CYC,
  parameter int WAKE_FULL_CYCLES = `WAKE_SD_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conversion_select_n,
  input  wire logic        serial_clock,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  output logic             sample_hold,
  output logic             analog_on,
  output logic             reference_on
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // True when a count has reached a one-based edge number
  function automatic logic edge_is(input logic [4:0]  cnt,
                                   input int unsigned num);
    return cnt == 5'(num - 1);
  endfunction : edge_is

  // True when three frame bits carry a register select code
  function automatic logic code_is(input logic [2:0] top,
                                   input logic [2:0] code);
    return top == code;
  endfunction : code_is

  // Range value from eleven bits: two per channel, middle pair zero
  function automatic logic [5:0] range_bits(input logic [10:0] rx);
    return {rx[7:6], 2'h0, rx[3:2]};
  endfunction : range_bits

  // Status word in the layout software reads
  function automatic logic [31:0] status_word(input logic       ref_up,
                                              input logic       an_up,
                                              input logic       held,
                                              input pwr_state_t state);
    return {26'h0000000, ref_up, an_up, held, state};
  endfunction : status_word

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] din_sync;
  logic       cs_prev;
  logic       sclk_prev;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cs_sync   <= 2'h3;
      sclk_sync <= 2'h0;
      din_sync  <= 2'h0;
      cs_prev   <= 1'b1;
      sclk_prev <= 1'b0;
    end else begin
      cs_sync   <= {cs_sync[0], conversion_select_n};
      sclk_sync <= {sclk_sync[0], serial_clock};
      din_sync  <= {din_sync[0], serial_data_in};
      cs_prev   <= cs_sync[1];
      sclk_prev <= sclk_sync[1];
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic din_bit;

  assign cs_fall   = cs_prev & ~cs_sync[1];
  assign cs_rise   = ~cs_prev & cs_sync[1];
  assign sclk_rise = ~sclk_prev & sclk_sync[1];
  assign sclk_fall = sclk_prev & ~sclk_sync[1];
  assign din_bit   = din_sync[1];

  // ****************************************************************
  // Frame counters
  // ****************************************************************
  logic       active;
  logic [4:0] rise_cnt;
  logic [4:0] fall_cnt;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      active   <= 1'b0;
      rise_cnt <= 5'h00;
      fall_cnt <= 5'h00;
    end else if (cs_fall) begin
      active   <= 1'b1;
      rise_cnt <= 5'h00;
      fall_cnt <= 5'h00;
    end else if (cs_rise) begin
      active <= 1'b0;
    end else if (active) begin
      if (sclk_rise)
        rise_cnt <= rise_cnt + 5'h01;
      if (sclk_fall) begin
        fall_cnt <= fall_cnt + 5'h01;
        if (edge_is(fall_cnt, `FRAME_BITS))
          active <= 1'b0;
      end
    end
  end

  // Select rising clears active, so an abort skips every latch edge
  logic at_track_edge;
  logic at_ctrl_edge;
  logic at_range_edge;

  assign at_track_edge = active && !cs_rise && sclk_rise
                         && edge_is(rise_cnt, `TRACK_EDGE);
  assign at_ctrl_edge  = active && !cs_rise && sclk_rise
                         && edge_is(rise_cnt, `CTRL_EDGE);
  assign at_range_edge = active && !cs_rise && sclk_fall
                         && edge_is(fall_cnt, `RANGE_EDGE);

  // ****************************************************************
  // Input shift register
  // ****************************************************************
  // First bit taken at select falling, the rest on serial falling edges
  logic [15:0] rx_bits;

  always_ff @(posedge ref_clk) begin
    if (srst)
      rx_bits <= 16'h0000;
    else if (cs_fall)
      rx_bits <= {15'h0000, din_bit};
    else if (active && sclk_fall && fall_cnt < 5'(`FRAME_BITS - 1))
      rx_bits <= {rx_bits[14:0], din_bit};
  end

  // Address bits sit at the top once enough bits have arrived
  logic ctrl_hit;
  logic range_hit;

  // rx holds 15 bits at the control edge, 11 at the range edge
  assign ctrl_hit  = code_is(rx_bits[14:12], `CODE_CTRL);
  assign range_hit = code_is(rx_bits[10:8], `CODE_RANGE);

  // ****************************************************************
  // On-chip registers
  // ****************************************************************
  logic [11:0] control;
  logic [5:0]  range_sel;
  logic [12:0] conv_data;
  logic        ctrl_load;

  assign ctrl_load = at_ctrl_edge && ctrl_hit;

  always_ff @(posedge ref_clk) begin
    if (srst)
      control <= `CTRL_RESET;
    else if (ctrl_load)
      control <= rx_bits[11:0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      range_sel <= `RANGE_RESET;
    else if (at_range_edge && range_hit)
      range_sel <= range_bits(rx_bits[10:0]);
  end

  // ****************************************************************
  // Result word output
  // ****************************************************************
  logic [14:0] tx_bits;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_bits            <= 15'h0000;
      serial_data_out    <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else if (cs_fall) begin
      tx_bits            <= {1'b0, control[`CHAN_BIT],
                             conv_data};
      serial_data_out    <= 1'b0;
      serial_data_out_oe <= 1'b1;
    end else if (cs_rise) begin
      serial_data_out_oe <= 1'b0;
    end else if (active && sclk_fall) begin
      serial_data_out <= tx_bits[14];
      tx_bits         <= {tx_bits[13:0], 1'b0};
      if (edge_is(fall_cnt, `FRAME_BITS))
        serial_data_out_oe <= 1'b0;
    end
  end

  // ****************************************************************
  // Power-mode state machine
  // ****************************************************************
  pwr_state_t  pwr_state;
  logic [15:0] wake_cnt;
  logic [1:0]  next_pm;

  // Mode in force after this edge: new bits only if the write lands
  assign next_pm = ctrl_load ? {rx_bits[`PM_HI_BIT], rx_bits[`PM_LO_BIT]}
                             : {control[`PM_HI_BIT], control[`PM_LO_BIT]};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwr_state <= PWR_ON;
      wake_cnt  <= 16'h0000;
    end else if (at_ctrl_edge) begin
      unique case (next_pm)
        2'h3: pwr_state <= PWR_FULL_SD;
        2'h2: pwr_state <= PWR_AUTO_SD;
        2'h1: pwr_state <= PWR_STANDBY;
        2'h0: begin
          if (pwr_state == PWR_FULL_SD) begin
            pwr_state <= PWR_WAKE;
            wake_cnt  <= 16'(WAKE_FULL_CYCLES);
          end
        end
      endcase
    end else begin
      unique case (pwr_state)
        PWR_AUTO_SD: begin
          if (cs_rise) begin
            pwr_state <= PWR_WAKE;
            wake_cnt  <= 16'(WAKE_SD_CYCLES);
          end
        end
        PWR_STANDBY: begin
          if (cs_rise) begin
            pwr_state <= PWR_WAKE;
            wake_cnt  <= 16'(`WAKE_SB_CYC);
          end
        end
        PWR_WAKE: begin
          if (wake_cnt <= 16'h0001)
            pwr_state <= PWR_ON;
          else
            wake_cnt <= wake_cnt - 16'h0001;
        end
        PWR_ON, PWR_FULL_SD: ;
      endcase
    end
  end

  // ****************************************************************
  // Track-and-hold and power outputs
  // ****************************************************************
  logic sleeping;

  assign sleeping = pwr_state == PWR_AUTO_SD
                    || pwr_state == PWR_STANDBY;

  always_ff @(posedge ref_clk) begin
    if (srst)
      sample_hold <= 1'b0;
    else if (cs_fall)
      sample_hold <= 1'b1;
    else if (sleeping && cs_rise)
      sample_hold <= 1'b0;
    else if (at_track_edge)
      sample_hold <= 1'b0;
    else if (at_ctrl_edge && (next_pm == 2'h2 || next_pm == 2'h1))
      sample_hold <= 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      analog_on    <= 1'b1;
      reference_on <= 1'b0;
    end else begin
      analog_on    <= pwr_state == PWR_ON;
      reference_on <= control[`REF_BIT]
                      && pwr_state != PWR_FULL_SD
                      && pwr_state != PWR_AUTO_SD;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic access_done;
  logic addr_ok;

  assign access_done = psel && penable && pready;
  assign addr_ok     = paddr == `OFF_CTRL || paddr == `OFF_RANGE
                       || paddr == `OFF_STATUS || paddr == `OFF_CONV;

  always_ff @(posedge ref_clk) begin
    if (srst)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= !addr_ok;
      unique case (paddr)
        `OFF_CTRL:   prdata <= {20'h00000, control};
        `OFF_RANGE:  prdata <= {26'h0000000, range_sel};
        `OFF_STATUS: prdata <= status_word(reference_on, analog_on,
                                           sample_hold, pwr_state);
        `OFF_CONV:   prdata <= {19'h00000, conv_data};
        default:     prdata <= 32'h0000_0000;
      endcase
    end else begin
      // Answer stands for the pready cycle only
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      conv_data <= `CONV_RESET;
    else if (access_done && pwrite && paddr == `OFF_CONV)
      conv_data <= pwdata[12:0];
  end

endmodule : adc_frame_ctrl
`default_nettype wire

// File: bench/adc_frame_ctrl_props.sv
// Purpose: Port checks for adc_frame_ctrl
// Assumes: Link pins act 2 to 4 ref_clk edges late
// Notes:   Bound to every design instance below
`default_nettype none
module adc_frame_props (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conversion_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic sample_hold
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_oe_on_select:
    assert property ($fell(conversion_select_n) |-> ##[2:4]
      (serial_data_out_oe && sample_hold && !serial_data_out))
    else $error("no drive after select fall");
  a_oe_off_rise:
    assert property ($rose(conversion_select_n) |-> ##[2:4]
      !serial_data_out_oe)
    else $error("drive kept after select rise");
  a_idle_float:
    assert property (conversion_select_n [*5] |-> !serial_data_out_oe)
    else $error("drive while deselected");
  a_dout_on_fall:
    assert property ($changed(serial_data_out) |->
      !$past(serial_clock, 2))
    else $error("data out moved off a falling edge");
  a_oe_end_frame:
    assert property ($fell(serial_data_out_oe) |->
      !$past(serial_clock, 2) || $past(conversion_select_n, 2))
    else $error("drive dropped at wrong time");
  a_hold_release:
    assert property ($fell(sample_hold) |-> serial_clock ||
      $past(serial_clock) || conversion_select_n)
    else $error("track resumed at wrong time");
  a_pready_pulse:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_pready_time:
    assert property (psel && !penable |-> ##2
      (pready && psel && penable))
    else $error("pready not in second access cycle");
  a_slverr_pair:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule : adc_frame_props
bind adc_frame_ctrl adc_frame_props i_props (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr),
  .conversion_select_n(conversion_select_n),
  .serial_clock(serial_clock), .serial_data_out(serial_data_out),
  .serial_data_out_oe(serial_data_out_oe), .sample_hold(sample_hold));
`default_nettype wire

// File: bench/host_serial_model.sv
// Purpose: Host serial master on the link
// Assumes: 800 ns serial clock, idle low
// Notes:   Quiet gap is a plain default
`default_nettype none
module host_serial_model (
  input  wire logic ref_clk,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe,
  output logic      conversion_select_n,
  output logic      serial_clock,
  output logic      serial_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 4;
  localparam int QUIET_GAP = 8;
  initial begin
    conversion_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_cyc
  // Frame bit 1 set up before select falls
  task automatic frame(input logic [15:0] d, input int nclk,
                       input bit stay_low, output logic [15:0] q,
                       output logic oe_all);
    logic [15:0] sh;
    sh = d;
    q = 16'h0000;
    oe_all = 1'b1;
    @(posedge ref_clk);
    serial_data_in <= sh[15];
    wait_cyc(HALF);
    conversion_select_n <= 1'b0;
    for (int k = 1; k <= nclk; k++) begin
      wait_cyc(HALF);
      serial_clock <= 1'b1;
      sh = sh << 1;
      serial_data_in <= sh[15];
      // Released line reads as the inverse of its last value
      q[16-k] = serial_data_out_oe ? serial_data_out : ~serial_data_out;
      oe_all = oe_all & serial_data_out_oe;
      wait_cyc(HALF);
      serial_clock <= 1'b0;
    end
    wait_cyc(HALF);
    serial_data_in <= ~serial_data_in;
    if (!stay_low) begin
      conversion_select_n <= 1'b1;
    end
    wait_cyc(QUIET_GAP);
  endtask : frame
  task automatic release_select();
    @(posedge ref_clk);
    conversion_select_n <= 1'b1;
    wait_cyc(QUIET_GAP);
  endtask : release_select
endmodule : host_serial_model
`default_nettype wire

// File: bench/tb_adc_frame_ctrl.sv
// Purpose: Self-checking bench for adc_frame_ctrl
// Assumes: Host model drives the link pins
// Notes:   Shutdown wake counts shortened to WAKE cycles
`default_nettype none
module tb_adc_frame_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_frame_pkg::*;
  localparam int WAKE = 200;
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, ok;
  logic        cs_n, sclk, sdi, sdo, sdo_oe, hold, an_on, ref_on;
  logic [15:0] q;
  int          err_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  always #50 ref_clk = ~ref_clk;
  adc_frame_ctrl #(.WAKE_SD_CYCLES(WAKE), .WAKE_FULL_CYCLES(WAKE)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conversion_select_n(cs_n),
    .serial_clock(sclk), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_out_oe(sdo_oe), .sample_hold(hold), .analog_on(an_on),
    .reference_on(ref_on));
  host_serial_model i_host (
    .ref_clk(ref_clk), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
    .conversion_select_n(cs_n), .serial_clock(sclk), .serial_data_in(sdi));
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string nm);
    apb(1'b0, a, 32'h0, rd, er);
    chk(nm, exp, rd);
  endtask : rdchk
  function automatic logic [31:0] st(logic r, an, h, pwr_state_t s);
    return {26'h0, r, an, h, s};
  endfunction : st
  function automatic logic [15:0] fr(logic [11:0] c);
    return {3'b100, c, 1'b0};
  endfunction : fr
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("pins", 32'h2, {28'h0, sdo_oe, hold, an_on, ref_on});
    rdchk(8'h08, st(0, 1, 0, PWR_ON), "stat");
    apb(1'b1, 8'h0C, 32'h1ABC, rd, er);
    rdchk(8'h0C, 32'h1ABC, "conv");
    apb(1'b1, 8'h00, 32'hFFF, rd, er);
    rdchk(8'h00, 32'h0, "ctrl");
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk("slverr", 32'h1, {31'h0, er});
    i_host.frame(fr(12'h202), 16, 1'b0, q, ok);
    chk("word", 32'h1ABC, {16'h0, q});
    chk("oe", 32'h1, {31'h0, ok});
    rdchk(8'h00, 32'h202, "ctrl");
    rdchk(8'h08, st(1, 1, 0, PWR_ON), "stat");
    i_host.frame(fr(12'hC02) & 16'h7FFF, 16, 1'b0, q, ok);
    chk("word", 32'h3ABC, {16'h0, q});
    chk("oe_end", 32'h0, {31'h0, sdo_oe});
    rdchk(8'h00, 32'h202, "ctrl");
    i_host.frame(16'hDFFE, 16, 1'b0, q, ok);
    i_host.frame(16'hB180, 16, 1'b0, q, ok);
    rdchk(8'h04, 32'h23, "range");
    rdchk(8'h00, 32'h202, "ctrl");
    i_host.frame(16'hA800, 12, 1'b0, q, ok);
    rdchk(8'h04, 32'h10, "range");
    i_host.frame(fr(12'hC02), 14, 1'b0, q, ok);
    chk("oe_abort", 32'h0, {31'h0, sdo_oe});
    rdchk(8'h00, 32'h202, "ctrl");
    rdchk(8'h08, st(1, 1, 0, PWR_ON), "stat");
    i_host.frame(fr(12'hC02), 16, 1'b0, q, ok);
    rdchk(8'h08, st(0, 0, 0, PWR_FULL_SD), "stat");
    i_host.frame(fr(12'h202), 16, 1'b0, q, ok);
    rdchk(8'h08, st(1, 0, 0, PWR_WAKE), "stat");
    repeat (WAKE) @(posedge ref_clk);
    rdchk(8'h08, st(1, 1, 0, PWR_ON), "stat");
    i_host.frame(fr(12'h402), 16, 1'b1, q, ok);
    rdchk(8'h08, st(1, 0, 1, PWR_STANDBY), "stat");
    i_host.release_select();
    repeat (8) @(posedge ref_clk);
    rdchk(8'h08, st(1, 1, 0, PWR_ON), "stat");
    i_host.frame(fr(12'h802), 16, 1'b1, q, ok);
    rdchk(8'h08, st(0, 0, 1, PWR_AUTO_SD), "stat");
    i_host.release_select();
    rdchk(8'h08, st(1, 0, 0, PWR_WAKE), "stat");
    repeat (WAKE) @(posedge ref_clk);
    rdchk(8'h08, st(1, 1, 0, PWR_ON), "stat");
    i_host.frame(fr(12'h002), 16, 1'b0, q, ok);
    chk("word", 32'h1ABC, {16'h0, q});
    rdchk(8'h08, st(1, 1, 0, PWR_ON), "stat");
    end_sim();
  end
endmodule : tb_adc_frame_ctrl
`default_nettype wire
